// ---- src/cwp_top.sv ----
// configuration word two decode and memory protection
// assumes a classic wishbone master and same-clock nonvolatile/programming logic
//
// Summary of operation
// - lvp field 1 allows low-voltage entry; 0 demands high voltage on master clear.
// - refuse programming lvp to 0 during a low-voltage-entered session.
// - debug field 1 frees the programming pins as gpio; 0 gives them to debugger.
// - brown-out trip select 1 picks the low level, 0 the high level.
// - stack fault reset enable 1 resets on stack faults, 0 does not.
// - pll config enable 1 switches the four-times multiplier on.
// - unimplemented bits read one; programmer writes reserved bit 4 as one.
// - self-write protect decodes to none, 000-1ff, 000-fff or everything.
// - program read protect 0 blocks external access; external reads give zero.
// - cpu program reads always work; self-writes gated only by self-write protect.
// - eeprom read protect 0 blocks external eeprom access, cpu access stays.
// - program and eeprom protection act independently, never on internal access.
// - four user id words at 8000h-8003h, readable and writable.
// - read-only identifier at 8006h: part code 13-5, revision 4-0.
// - blank or erased configuration word reads all ones.
// - pll config enable 1 overrides the soft pll enable bit.
// - push past level 16 or pop below first sets overflow/underflow flag.
//
// Local design decision: the Wishbone interface to the registers.
`default_nettype none
`include "cwp_defines.svh"
module cwp_top
   import cwp_pkg::*;
#(
   parameter int STACK_DEPTH = 16,
   parameter logic [8:0] PART_CODE = 9'h15a, // arbitrary value
   parameter logic [4:0] SILICON_STEP = 5'h01 // arbitrary value
)(
   input wire logic CLK, // system clock, 100 MHz
   input wire logic RSTN, // synchronous reset, low
   input wire logic CYC_I, // wishbone cycle
   input wire logic STB_I, // wishbone strobe
   input wire logic WE_I, // wishbone write
   input wire logic [17:0] ADR_I, // wishbone byte address
   input wire logic [3:0] SEL_I, // wishbone byte lanes
   input wire logic [31:0] DAT_I, // wishbone write data
   output logic [31:0] DAT_O, // wishbone read data
   output logic ACK_O, // wishbone acknowledge
   input wire logic [13:0] NV_CFG2, // stored configuration word
   input wire logic LV_ENTRY_PIN, // session entered by low voltage
   output logic CFG_PGM_STB, // program the configuration word, pulse
   output logic [13:0] CFG_PGM_DATA, // word to program
   output logic LVP_ENTRY_EN, // low-voltage entry permitted
   output logic HV_ENTRY_REQ, // entry needs high voltage
   output logic DEBUG_EN, // debugger owns the programming pins
   output logic PROG_PINS_GPIO, // programming pins are general io
   output logic BOR_LOW_TRIP, // low brown-out trip selected
   output logic PLL_EN, // four-times multiplier on
   input wire logic STK_PUSH, // stack push pulse
   input wire logic STK_POP, // stack pop pulse
   output logic STACK_RESET, // reset request, pulse
   input wire logic SELF_WR_REQ, // cpu self-write request
   input wire logic [12:0] SELF_WR_ADDR, // cpu self-write word address
   output logic SELF_WR_OK, // self-write allowed
   input wire logic EXT_REQ, // programmer access request
   input wire logic EXT_WE, // programmer access is a write
   input wire logic EXT_EEPROM, // 1 eeprom, 0 program memory
   input wire logic [13:0] EXT_MEM_DATA, // data from the memory array
   input wire logic PROGRAM_READ_PROTECT_N, // program memory protected, low
   input wire logic EEPROM_READ_PROTECT_N, // data eeprom protected, low
   output logic EXT_GRANT, // access may proceed
   output logic [13:0] EXT_RDATA // data returned to the programmer
);
   // active configuration and sequencing
   cwp_state_t state_r, state_nxt;
   logic [13:0] cfg_r, cfg_nxt;
   // protection bits of the other configuration word, bit 0 program, bit 1 eeprom
   logic [1:0] prot_n_r, prot_n_nxt;
   // register file
   logic [13:0] uid_r [4];
   logic [13:0] uid_nxt [4];
   logic spll_r, spll_nxt;
   logic ovf_r, ovf_nxt, unf_r, unf_nxt, ref_r, ref_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic pgm_stb_r, pgm_stb_nxt;
   logic [13:0] pgm_data_r, pgm_data_nxt;
   logic [13:0] ext_rd_r, ext_rd_nxt;
   logic lv_meta_r, lv_sync_r;
   logic ovf_ev, unf_ev;
   logic req, wr, rd_en;
   logic [15:0] idx;
   logic blocked;
   cwp_wrt_t wrt;

   // blank bits and unimplemented bits both read as one
   function automatic logic [13:0] cfg_view(input logic [13:0] w);
      cfg_view = w | `CWP_CFG_UNIMPL;
   endfunction

   // lowest word address that a self-write may touch, per protection code
   function automatic logic self_ok(input cwp_wrt_t m, input logic [12:0] a);
      unique case (m)
         CWP_WRT_OFF: self_ok = 1'b1;
         CWP_WRT_SMALL: self_ok = (a >= `CWP_WRT_BOUND_SMALL);
         CWP_WRT_HALF: self_ok = (a >= `CWP_WRT_BOUND_HALF);
         CWP_WRT_ALL: self_ok = 1'b0;
      endcase
   endfunction

   assign req = CYC_I && STB_I && !ack_r;
   // a write lands at the edge where ack is high; the master still holds it there
   assign wr = CYC_I && STB_I && ack_r && WE_I && SEL_I[0];
   assign rd_en = req && !WE_I;
   assign idx = ADR_I[17:2];
   assign wrt = cwp_wrt_t'(cfg_r[`CWP_CFG_WRT_HI:`CWP_CFG_WRT_LO]);

   // pin level crosses two flops before use
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         lv_meta_r <= 1'b0;
         lv_sync_r <= 1'b0;
      end
      else
      begin
         lv_meta_r <= LV_ENTRY_PIN;
         lv_sync_r <= lv_meta_r;
      end
   end

   cwp_stack_mon #(
      .DEPTH(STACK_DEPTH)
   ) u_stack (
      .clk(CLK),
      .rstn(RSTN),
      .push(STK_PUSH),
      .pop(STK_POP),
      .overflow(ovf_ev),
      .underflow(unf_ev)
   );

   // capture the stored word once after reset, then freeze it
   always_comb
   begin
      state_nxt = state_r;
      cfg_nxt = cfg_r;
      prot_n_nxt = prot_n_r;
      unique case (state_r)
         CWP_ST_LOAD:
         begin
            cfg_nxt = NV_CFG2;
            prot_n_nxt = {EEPROM_READ_PROTECT_N, PROGRAM_READ_PROTECT_N};
            state_nxt = CWP_ST_RUN;
         end
         CWP_ST_RUN: state_nxt = CWP_ST_RUN;
         default: state_nxt = CWP_ST_LOAD;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         state_r <= CWP_ST_LOAD;
         cfg_r <= `CWP_CFG_BLANK;
         prot_n_r <= 2'h3; // blank word leaves both memories open
      end
      else
      begin
         state_r <= state_nxt;
         cfg_r <= cfg_nxt;
         prot_n_r <= prot_n_nxt;
      end
   end

   // bus writes, status flags and configuration programming
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         uid_nxt[i] = uid_r[i];
      spll_nxt = spll_r;
      pgm_stb_nxt = 1'b0;
      pgm_data_nxt = pgm_data_r;
      ovf_nxt = ovf_r;
      unf_nxt = unf_r;
      ref_nxt = ref_r;
      if (wr && idx >= `CWP_IDX_USERID0 && idx <= `CWP_IDX_USERID3)
         uid_nxt[idx[1:0]] = DAT_I[13:0];
      if (wr && idx == `CWP_IDX_CTRL)
         spll_nxt = DAT_I[`CWP_CTRL_SPLL];
      if (wr && idx == `CWP_IDX_CFG2)
      begin
         // a low-voltage session must not lock itself out of low voltage
         if (lv_sync_r && !DAT_I[`CWP_CFG_LVP])
            ref_nxt = 1'b1;
         else
         begin
            pgm_stb_nxt = 1'b1;
            pgm_data_nxt = DAT_I[13:0] | (14'h0001 << `CWP_CFG_RSVD);
         end
      end
      // write one to clear; a new event in the same cycle wins
      if (wr && idx == `CWP_IDX_STATUS)
      begin
         if (DAT_I[`CWP_STAT_OVF])
            ovf_nxt = 1'b0;
         if (DAT_I[`CWP_STAT_UNF])
            unf_nxt = 1'b0;
         if (DAT_I[`CWP_STAT_REFUSED])
            ref_nxt = 1'b0;
      end
      if (ovf_ev)
         ovf_nxt = 1'b1;
      if (unf_ev)
         unf_nxt = 1'b1;
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         for (int i = 0; i < 4; i++)
            uid_r[i] <= `CWP_USERID_RST;
         spll_r <= 1'b0;
         pgm_stb_r <= 1'b0;
         pgm_data_r <= `CWP_CFG_BLANK;
         ovf_r <= 1'b0;
         unf_r <= 1'b0;
         ref_r <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
            uid_r[i] <= uid_nxt[i];
         spll_r <= spll_nxt;
         pgm_stb_r <= pgm_stb_nxt;
         pgm_data_r <= pgm_data_nxt;
         ovf_r <= ovf_nxt;
         unf_r <= unf_nxt;
         ref_r <= ref_nxt;
      end
   end

   // read mux and one-cycle acknowledge; unmapped reads return zero
   always_comb
   begin
      ack_nxt = CYC_I && STB_I && !ack_r;
      dat_nxt = dat_r;
      if (rd_en)
      begin
         dat_nxt = 32'h0000_0000;
         if (idx >= `CWP_IDX_USERID0 && idx <= `CWP_IDX_USERID3)
            dat_nxt[13:0] = uid_r[idx[1:0]];
         else if (idx == `CWP_IDX_PART_AND_REVISION_ID)
            dat_nxt[13:0] = {PART_CODE, SILICON_STEP};
         else if (idx == `CWP_IDX_CFG2)
            dat_nxt[13:0] = cfg_view(cfg_r);
         else if (idx == `CWP_IDX_CTRL)
            dat_nxt[`CWP_CTRL_SPLL] = spll_r;
         else if (idx == `CWP_IDX_STATUS)
            dat_nxt[3:0] = {state_r == CWP_ST_RUN, ref_r, unf_r, ovf_r};
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
      begin
         ack_r <= 1'b0;
         dat_r <= 32'h0000_0000;
      end
      else
      begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
      end
   end

   // external access gate; each memory has its own protection bit
   // cpu reads and writes never pass this gate, so protection cannot stall code
   always_comb
   begin
      blocked = EXT_EEPROM ? !prot_n_r[1] : !prot_n_r[0];
      ext_rd_nxt = ext_rd_r;
      if (EXT_REQ && !EXT_WE)
         ext_rd_nxt = EXT_GRANT ? EXT_MEM_DATA : 14'h0000;
   end

   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         ext_rd_r <= 14'h0000;
      else
         ext_rd_r <= ext_rd_nxt;
   end

   assign DAT_O = dat_r;
   assign ACK_O = ack_r;
   assign CFG_PGM_STB = pgm_stb_r;
   assign CFG_PGM_DATA = pgm_data_r;
   assign EXT_RDATA = ext_rd_r;
   assign EXT_GRANT = EXT_REQ && !blocked;
   assign SELF_WR_OK = SELF_WR_REQ && self_ok(wrt, SELF_WR_ADDR);
   assign LVP_ENTRY_EN = cfg_r[`CWP_CFG_LVP];
   assign HV_ENTRY_REQ = !cfg_r[`CWP_CFG_LVP];
   assign DEBUG_EN = !cfg_r[`CWP_CFG_DEBUG];
   assign PROG_PINS_GPIO = cfg_r[`CWP_CFG_DEBUG];
   assign BOR_LOW_TRIP = cfg_r[`CWP_CFG_BROWNOUT_TRIP_SELECT];
   assign PLL_EN = cfg_r[`CWP_CFG_PLL_CONFIG_ENABLE] || spll_r;
   assign STACK_RESET = cfg_r[`CWP_CFG_STACK_FAULT_RESET_ENABLE] && (ovf_ev || unf_ev);
endmodule // cwp_top
`default_nettype wire

// ---- shared/cwp_defines.svh ----
// constants for the configuration word and memory protection block
// assumes a 32-bit wishbone slave with word-aligned registers
`ifndef CWP_DEFINES_SVH
`define CWP_DEFINES_SVH

// register indices; byte address is four times the index
`define CWP_IDX_USERID0 16'h8000
`define CWP_IDX_USERID3 16'h8003
`define CWP_IDX_PART_AND_REVISION_ID 16'h8006
`define CWP_IDX_CFG2 16'h8008
`define CWP_IDX_CTRL 16'h8010
`define CWP_IDX_STATUS 16'h8011

// configuration word two fields
`define CWP_CFG_LVP 13
`define CWP_CFG_DEBUG 12
`define CWP_CFG_BROWNOUT_TRIP_SELECT 10
`define CWP_CFG_STACK_FAULT_RESET_ENABLE 9
`define CWP_CFG_PLL_CONFIG_ENABLE 8
`define CWP_CFG_RSVD 4
`define CWP_CFG_WRT_HI 1
`define CWP_CFG_WRT_LO 0
`define CWP_CFG_UNIMPL 14'h08ec
`define CWP_CFG_BLANK 14'h3fff

// identifier word layout
`define CWP_ID_PART_HI 13
`define CWP_ID_PART_LO 5
`define CWP_ID_REV_HI 4

// control and status bits
`define CWP_CTRL_SPLL 0
`define CWP_STAT_OVF 0
`define CWP_STAT_UNF 1
`define CWP_STAT_REFUSED 2
`define CWP_STAT_LOADED 3

// self-write protection bounds (program word addresses)
`define CWP_WRT_BOUND_SMALL 13'h0200
`define CWP_WRT_BOUND_HALF 13'h1000
`define CWP_USERID_RST 14'h3fff

`endif

// ---- shared/cwp_pkg.sv ----
// types shared by the configuration word protection block
// assumes cwp_defines.svh holds all numeric constants
`default_nettype none
package cwp_pkg;
   // configuration capture sequence, one-hot
   typedef enum logic [1:0] {
      CWP_ST_LOAD = 2'b01,
      CWP_ST_RUN = 2'b10
   } cwp_state_t;

   // self-write protection encodings
   typedef enum logic [1:0] {
      CWP_WRT_ALL = 2'b00,
      CWP_WRT_HALF = 2'b01,
      CWP_WRT_SMALL = 2'b10,
      CWP_WRT_OFF = 2'b11
   } cwp_wrt_t;
endpackage
`default_nettype wire

// ---- src/cwp_stack_mon.sv ----
// hardware return stack depth monitor
// assumes push and pop are single-cycle pulses from the same clock domain
`default_nettype none
`include "cwp_defines.svh"
module cwp_stack_mon
   import cwp_pkg::*;
#(
   parameter int DEPTH = 16
)(
   input wire logic clk, // system clock
   input wire logic rstn, // synchronous reset, low
   input wire logic push, // one call or interrupt
   input wire logic pop, // one return
   output logic overflow, // push beyond the last level
   output logic underflow // pop with the stack empty
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   logic [CW-1:0] depth_r;
   logic [CW-1:0] depth_nxt;

   // a simultaneous push and pop leaves the depth as it is
   always_comb
   begin
      depth_nxt = depth_r;
      overflow = 1'b0;
      underflow = 1'b0;
      if (push && !pop)
      begin
         if (depth_r == FULL)
            overflow = 1'b1;
         else
            depth_nxt = depth_r + 1'b1;
      end
      else if (pop && !push)
      begin
         if (depth_r == '0)
            underflow = 1'b1;
         else
            depth_nxt = depth_r - 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
         depth_r <= '0;
      else
         depth_r <= depth_nxt;
   end
endmodule // cwp_stack_mon
`default_nettype wire

// ---- tb/cwp_props.sv ----
// assertions on the decoded configuration and protection outputs
// assumes a bind into cwp_top; the word is captured in the first cycle after reset
`default_nettype none
module cwp_props
   import cwp_pkg::*;
(
   input wire logic CLK, // clock
   input wire logic RSTN, // reset, low
   input wire logic [13:0] NV_CFG2, // stored word
   input wire logic LV_ENTRY_PIN, // lv session
   input wire logic CFG_PGM_STB, // program pulse
   input wire logic [13:0] CFG_PGM_DATA, // word programmed
   input wire logic LVP_ENTRY_EN, // lv entry
   input wire logic HV_ENTRY_REQ, // hv entry
   input wire logic DEBUG_EN, // debugger
   input wire logic PROG_PINS_GPIO, // pins free
   input wire logic BOR_LOW_TRIP, // bor level
   input wire logic PLL_EN, // multiplier
   input wire logic STK_PUSH, // push
   input wire logic STK_POP, // pop
   input wire logic STACK_RESET, // stack reset
   input wire logic SELF_WR_REQ, // self-write
   input wire logic [12:0] SELF_WR_ADDR, // its address
   input wire logic SELF_WR_OK, // allowed
   input wire logic EXT_REQ, // external access
   input wire logic EXT_WE, // external write
   input wire logic EXT_EEPROM, // eeprom target
   input wire logic PROGRAM_READ_PROTECT_N, // program protect, low
   input wire logic EEPROM_READ_PROTECT_N, // eeprom protect, low
   input wire logic EXT_GRANT, // granted
   input wire logic [13:0] EXT_RDATA // external data
);
   logic [2:0] run_cnt_r, run_cnt_nxt;
   logic [13:0] cfg_r, cfg_nxt;
   logic [1:0] prot_r, prot_nxt;
   logic run_ok, wr_ok;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   // own copy of the word; decode, self-write and gate outputs are judged only once capture has settled
   always_comb
   begin
      run_cnt_nxt = (run_cnt_r == 3'h7) ? run_cnt_r : run_cnt_r + 3'h1;
      cfg_nxt = (run_cnt_r == 3'h0) ? NV_CFG2 : cfg_r;
      prot_nxt = prot_r;
      if (run_cnt_r == 3'h0)
         prot_nxt = {EEPROM_READ_PROTECT_N, PROGRAM_READ_PROTECT_N};
   end
   always_ff @(posedge CLK)
   begin
      run_cnt_r <= RSTN ? run_cnt_nxt : 3'h0;
      cfg_r <= RSTN ? cfg_nxt : cfg_r;
      prot_r <= RSTN ? prot_nxt : prot_r;
   end
   assign run_ok = (run_cnt_r == 3'h7);
   // writable part of program memory for each protection code
   always_comb
   begin
      case (cfg_r[1:0])
         2'h3: wr_ok = 1'b1;
         2'h2: wr_ok = (SELF_WR_ADDR >= 13'h0200);
         2'h1: wr_ok = (SELF_WR_ADDR >= 13'h1000);
         default: wr_ok = 1'b0;
      endcase
   end
   a_lvp_entry: assert property (run_ok |-> LVP_ENTRY_EN == cfg_r[13]
      && HV_ENTRY_REQ != cfg_r[13]) else $error("entry mode decode wrong");
   a_debug_pins: assert property (run_ok |-> DEBUG_EN != cfg_r[12]
      && PROG_PINS_GPIO == cfg_r[12]) else $error("debug pin decode wrong");
   a_bor_level: assert property (run_ok |-> BOR_LOW_TRIP == cfg_r[10])
      else $error("brown-out level wrong");
   a_pll_forced: assert property (run_ok && cfg_r[8] |-> PLL_EN)
      else $error("multiplier not forced on");
   a_cfg_held: assert property (run_ok && $past(run_ok) |->
      $stable({LVP_ENTRY_EN, DEBUG_EN, BOR_LOW_TRIP})) else $error("decode moved");
   a_lvp_kept: assert property (CFG_PGM_STB && $past(LV_ENTRY_PIN, 3) |-> CFG_PGM_DATA[13])
      else $error("lv enable cleared in lv session");
   a_self_write: assert property (run_ok && SELF_WR_REQ |-> SELF_WR_OK == wr_ok)
      else $error("self-write gate wrong");
   a_blocked_zero: assert property (EXT_REQ && !EXT_WE && !EXT_GRANT |=>
      EXT_RDATA == 14'h0) else $error("blocked read leaked data");
   a_stack_cause: assert property (STACK_RESET |-> cfg_r[9] && (STK_PUSH || STK_POP))
      else $error("stack reset without cause");
   a_ext_gate: assert property (run_ok && EXT_REQ |->
      EXT_GRANT == (EXT_EEPROM ? prot_r[1] : prot_r[0])) else $error("external gate wrong");
   c_stack_reset: cover property (STACK_RESET);
   c_program: cover property (CFG_PGM_STB);
   c_write_blocked: cover property (SELF_WR_REQ && !SELF_WR_OK);
endmodule // cwp_props
bind cwp_top cwp_props chk_u (.CLK, .RSTN, .NV_CFG2, .LV_ENTRY_PIN, .CFG_PGM_STB,
   .CFG_PGM_DATA, .LVP_ENTRY_EN, .HV_ENTRY_REQ, .DEBUG_EN, .PROG_PINS_GPIO, .BOR_LOW_TRIP,
   .PLL_EN, .STK_PUSH, .STK_POP, .STACK_RESET, .SELF_WR_REQ, .SELF_WR_ADDR, .SELF_WR_OK,
   .EXT_REQ, .EXT_WE, .EXT_EEPROM, .PROGRAM_READ_PROTECT_N, .EEPROM_READ_PROTECT_N,
   .EXT_GRANT, .EXT_RDATA);
`default_nettype wire

// ---- tb/cwp_prog_model.sv ----
// programmer tool and memory array at the external access port
// assumes one-cycle requests answered in the same cycle
`default_nettype none
module cwp_prog_model (
   input wire logic clk, // clock
   input wire logic rstn, // reset, low
   input wire logic go, // start one access
   input wire logic ee, // eeprom target
   input wire logic wr, // access is a write
   output logic ext_req, // request
   output logic ext_we, // write request
   output logic ext_ee, // target
   output logic [13:0] mem_data // array word
);
   logic [13:0] mem_nxt;
   // the word is valid only while accessed; idle it toggles so stale data matches only on alternate cycles
   always_comb
   begin
      mem_nxt = !rstn ? 14'h0 : (go ? 14'h1234 : ~mem_data);
   end
   always_ff @(posedge clk)
   begin
      ext_req <= go;
      ext_ee <= go & ee;
      ext_we <= go & wr;
      mem_data <= mem_nxt;
   end
endmodule // cwp_prog_model
`default_nettype wire

// ---- tb/cwp_tb_top.sv ----
// self-checking bench for the configuration protection block
// assumes registers at four times their index and a 100 MHz clock
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module cwp_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [8:0] ID_PART = 9'h0c3; // arbitrary value
   localparam logic [4:0] ID_STEP = 5'h02; // arbitrary value
   logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, we = 1'b0, lv = 1'b0, push = 1'b0, pop = 1'b0;
   logic swr = 1'b0, go = 1'b0, ee = 1'b0, ack, pgm_stb, stk_rst, sw_ok, grant, xreq, xee;
   logic lvp_en, hv_req, dbg_en, gpio, bor_low, pll_en;
   logic xw = 1'b0, xwe;
   logic [1:0] prot_n = 2'h3;
   logic [17:0] adr = 18'h0;
   logic [31:0] wdat = 32'h0, rd, dat_o;
   logic [13:0] cfg = 14'h3fff, pgm_data, xrdata, mem, pgm_last;
   logic [12:0] swa = 13'h0;
   logic [12:0] addrs [5] = '{13'h01ff, 13'h0200, 13'h0fff, 13'h1000, 13'h1fff};
   // stored word, then which of the five addresses accept a self-write
   logic [18:0] rows [4] = '{{14'h3fff, 5'h1f}, {14'h0012, 5'h0f}, {14'h1511, 5'h03},
      {14'h2a10, 5'h00}};
   int num_errors = 0, samples_checked = 0, stb_cnt = 0, rst_cnt = 0, cycles = 0;
   cwp_top #(.STACK_DEPTH(16), .PART_CODE(ID_PART), .SILICON_STEP(ID_STEP)) dut_u (
      .CLK(clk), .RSTN(rstn), .CYC_I(cyc), .STB_I(cyc), .WE_I(we), .ADR_I(adr),
      .SEL_I(4'hf), .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .NV_CFG2(cfg),
      .LV_ENTRY_PIN(lv), .CFG_PGM_STB(pgm_stb), .CFG_PGM_DATA(pgm_data),
      .LVP_ENTRY_EN(lvp_en), .HV_ENTRY_REQ(hv_req), .DEBUG_EN(dbg_en),
      .PROG_PINS_GPIO(gpio), .BOR_LOW_TRIP(bor_low), .PLL_EN(pll_en), .STK_PUSH(push),
      .STK_POP(pop), .STACK_RESET(stk_rst), .SELF_WR_REQ(swr), .SELF_WR_ADDR(swa),
      .SELF_WR_OK(sw_ok), .EXT_REQ(xreq), .EXT_WE(xwe), .EXT_EEPROM(xee),
      .PROGRAM_READ_PROTECT_N(prot_n[0]), .EEPROM_READ_PROTECT_N(prot_n[1]),
      .EXT_MEM_DATA(mem), .EXT_GRANT(grant), .EXT_RDATA(xrdata));
   cwp_prog_model prog_u (.clk(clk), .rstn(rstn), .go(go), .ee(ee), .wr(xw), .ext_req(xreq),
      .ext_we(xwe), .ext_ee(xee), .mem_data(mem));
   initial
   begin
      forever #5 clk = ~clk;
   end
   // hang guard plus counts of program strobes and stack resets
   always @(posedge clk)
   begin
      cycles++;
      if (pgm_stb === 1'b1) pgm_last = pgm_data;
      if (pgm_stb === 1'b1) stb_cnt++;
      if (stk_rst === 1'b1) rst_cnt++;
      if (cycles == 20000) num_errors++;
      if (cycles == 20000) end_sim();
   end
   task automatic end_sim();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // classic cycle, held until ack is sampled high; only the bench timeout ends a hang
   task automatic wb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= d;
      do
      begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
   endtask
   task automatic pulse(input int n, input logic p);
      repeat (n)
      begin
         @(posedge clk);
         push <= !p;
         pop <= p;
      end
      @(posedge clk);
      push <= 1'b0;
      pop <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic reset_with(input logic [13:0] c, input int n);
      @(posedge clk);
      rstn <= 1'b0;
      cfg <= c;
      repeat (n) @(posedge clk);
      rstn <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   initial
   begin
      reset_with(14'h3fff, 10);
      foreach (rows[i])
      begin
         reset_with(rows[i][18:5], 3);
         `CHK("lvp", rows[i][18], lvp_en)
         `CHK("hv", !rows[i][18], hv_req)
         `CHK("gpio", rows[i][17], gpio)
         `CHK("debug", !rows[i][17], dbg_en)
         `CHK("bor", rows[i][15], bor_low)
         `CHK("pll", rows[i][13], pll_en)
         wb(1'b0, 16'h8008, 32'h0);
         `CHK("word", {18'h0, rows[i][18:5] | 14'h08ec}, rd)
         foreach (addrs[j])
         begin
            @(posedge clk);
            swr <= 1'b1;
            swa <= addrs[j];
            @(negedge clk);
            `CHK("self write", rows[i][4 - j], sw_ok)
         end
         @(posedge clk);
         swr <= 1'b0;
      end
      reset_with(14'h3fff, 10);
      // identifier ignores writes; user words keep what is written
      wb(1'b1, 16'h8006, 32'h0);
      wb(1'b0, 16'h8006, 32'h0);
      `CHK("ident", {18'h0, ID_PART, ID_STEP}, rd)
      for (int k = 0; k < 4; k++)
      begin
         wb(1'b0, 16'h8000 + 16'(k), 32'h0);
         `CHK("id reset", 32'h3fff, rd)
         wb(1'b1, 16'h8000 + 16'(k), 32'h0a50 + k);
         wb(1'b0, 16'h8000 + 16'(k), 32'h0);
         `CHK("id word", 32'h0a50 + k, rd)
      end
      wb(1'b0, 16'h8005, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      wb(1'b1, 16'h8010, 32'h0);
      `CHK("pll forced", 1'b1, pll_en)
      cfg <= 14'h0;
      wb(1'b0, 16'h8008, 32'h0);
      `CHK("held word", 32'h3fff, rd)
      `CHK("held bor", 1'b1, bor_low)
      lv <= 1'b1;
      // let the pin pass the synchroniser before the refused write
      repeat (3) @(posedge clk);
      wb(1'b1, 16'h8008, 32'h1fff);
      wb(1'b0, 16'h8011, 32'h0);
      `CHK("refused", 1'b1, rd[2])
      `CHK("no strobe", 0, stb_cnt)
      wb(1'b1, 16'h8008, 32'h3ffe);
      repeat (4) @(posedge clk);
      `CHK("strobe", 1, stb_cnt)
      `CHK("programmed", 14'h3ffe, pgm_last)
      lv <= 1'b0;
      pulse(16, 1'b0);
      `CHK("full stack", 0, rst_cnt)
      pulse(1, 1'b0);
      `CHK("overflow reset", 1, rst_cnt)
      wb(1'b0, 16'h8011, 32'h0);
      `CHK("overflow flag", 1'b1, rd[0])
      wb(1'b1, 16'h8011, 32'h1);
      wb(1'b0, 16'h8011, 32'h0);
      `CHK("flag cleared", 1'b0, rd[0])
      reset_with(14'h3fff, 3);
      pulse(1, 1'b1);
      `CHK("underflow reset", 2, rst_cnt)
      wb(1'b0, 16'h8011, 32'h0);
      `CHK("underflow flag", 1'b1, rd[1])
      reset_with(14'h3cff, 3);
      pulse(17, 1'b0);
      `CHK("no stack reset", 2, rst_cnt)
      wb(1'b1, 16'h8010, 32'h1);
      @(negedge clk);
      `CHK("soft pll on", 1'b1, pll_en)
      wb(1'b1, 16'h8010, 32'h0);
      @(negedge clk);
      `CHK("soft pll off", 1'b0, pll_en)
      // no protection, then program memory locked, then eeprom locked
      for (int p = 0; p < 3; p++)
      begin
         prot_n <= ~2'(p);
         if (p > 0) reset_with(14'h3fff, 3);
         for (int x = 0; x < 4; x++)
         begin
            @(posedge clk);
            go <= 1'b1;
            ee <= x[0];
            xw <= x[1];
            @(posedge clk);
            go <= 1'b0;
            @(negedge clk);
            `CHK("grant", prot_n[x[0]], grant)
            @(negedge clk);
            if (!x[1]) `CHK("ext data", prot_n[x[0]] ? 14'h1234 : 14'h0, xrdata)
         end
      end
      end_sim();
   end
endmodule // cwp_tb_top
`default_nettype wire
